// >>> hw/pci_cfg_id_status_regs.vh
`ifndef PCI_CFG_ID_STATUS_REGS_VH
`define PCI_CFG_ID_STATUS_REGS_VH
// Register offsets on the host register port.
`define OFS_IDENT          16'hD000
`define OFS_STATUS_CMD     16'hD004
// Identification register fields.
`define ID_DEVICE_MSB      31
`define ID_DEVICE_LSB      16
`define ID_VENDOR_MSB      15
`define ID_VENDOR_LSB      0
// Status word bit positions.
`define ST_PAR_ERR         31
`define ST_SYS_ERR         30
`define ST_MABORT_RCVD     29
`define ST_TABORT_RCVD     28
`define ST_TABORT_SIG      27
`define ST_DSEL_MSB        26
`define ST_DSEL_LSB        25
`define ST_MDPE            24
`define ST_FBBCP           23
`define ST_66MCP           21
`define ST_CAPLIST         20
// Command word bit positions.
`define CMD_FBBEN          9
`define CMD_SEREN          8
`define CMD_PAR_RESP       6
// Devsel timing encodings.
`define DSEL_FAST          2'h0
`define DSEL_MEDIUM        2'h1
`define DSEL_SLOW          2'h2
`define DSEL_RESERVED      2'h3
// Link edges from address phase to devsel for medium timing.
`define DEVSEL_MEDIUM_EDGES 2'h2
// Event vector positions of the link-side inputs.
`define EV_RD_INIT_PERR    0
`define EV_WR_TGT_PERR     1
`define EV_ADDR_PERR       2
`define EV_SPC_PERR        3
`define EV_MST_ABORT       4
`define EV_MST_ABORT_SPC   5
`define EV_TGT_ABORT_RCVD  6
`define EV_TGT_ABORT_SIG   7
`define EV_MST_PERR        8
`define EV_ADDR_PHASE      9
`define EV_COUNT           10
`endif

// >>> hw/pci_cfg_id_status_regs.v
`timescale 1ns/10ps
`include "pci_cfg_id_status_regs.vh"

module pci_cfg_id_status_regs #(
  parameter [15:0] DEVICE_ID_RESET = 16'h1234,  // Arbitrary value.
  parameter [15:0] VENDOR_ID_RESET = 16'h5678   // Arbitrary value.
) (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        satellite_mode,
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  output reg         reg_blocked,
  input  wire        id_load,
  input  wire [31:0] id_load_data,
  input  wire        pci_clk,
  input  wire        rd_init_perr,
  input  wire        wr_tgt_perr,
  input  wire        addr_perr,
  input  wire        spc_perr,
  input  wire        mst_abort,
  input  wire        mst_abort_special,
  input  wire        tgt_abort_rcvd,
  input  wire        tgt_abort_sig,
  input  wire        mst_perr,
  input  wire        addr_phase,
  output wire        serr_out,
  output reg         serr_oe,
  output wire        devsel_out,
  output reg         devsel_oe,
  output wire        parity_response_enable,
  output wire [15:0] satellite_status_mirror
);

  // Raw link-side inputs gathered so one loop can synchronise them all.
  wire [`EV_COUNT-1:0] ev_raw;
  // Filtered link-side levels, updated only when two sync stages agree.
  wire [`EV_COUNT-1:0] ev_f;

  assign ev_raw = {addr_phase, mst_perr, tgt_abort_sig, tgt_abort_rcvd,
                   mst_abort_special, mst_abort, spc_perr, addr_perr,
                   wr_tgt_perr, rd_init_perr};

  // Each link input passes three flops; a change counts once the second
  // and third agree, which rejects a single metastable sample.
  genvar gi;
  generate
    for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg f_q;
      // Three-stage synchroniser with agreement filter.
      always @(posedge clk_sys) begin
        if (srst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          f_q  <= 1'b0;
        end else begin
          s1_q <= ev_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign ev_f[gi] = f_q;
    end
  endgenerate

  // Link clock synchroniser stages and filtered level.
  reg pclk_s1_q;
  reg pclk_s2_q;
  reg pclk_s3_q;
  reg pclk_f_q;
  // Filtered link clock one cycle earlier, for edge detection.
  reg pclk_prev_q;
  // One-cycle pulse on each sampled rising edge of the link clock.
  wire pci_edge;

  // The link clock is sampled like any pin; its delay matches the events.
  always @(posedge clk_sys) begin
    if (srst) begin
      pclk_s1_q   <= 1'b0;
      pclk_s2_q   <= 1'b0;
      pclk_s3_q   <= 1'b0;
      pclk_f_q    <= 1'b0;
      pclk_prev_q <= 1'b0;
    end else begin
      pclk_s1_q   <= pci_clk;
      pclk_s2_q   <= pclk_s1_q;
      pclk_s3_q   <= pclk_s2_q;
      pclk_prev_q <= pclk_f_q;
      if (pclk_s2_q == pclk_s3_q) begin
        pclk_f_q <= pclk_s3_q;
      end
    end
  end
  assign pci_edge = pclk_f_q & ~pclk_prev_q;

  // Identification register contents.
  reg  [31:0] ident_q;
  // Sticky error flags of the status word.
  reg         par_err_q;
  reg         sys_err_q;
  reg         mabort_rcvd_q;
  reg         tabort_rcvd_q;
  reg         tabort_sig_q;
  reg         mdpe_q;
  // Writable command bits kept by this bank.
  reg         par_resp_en_q;
  reg         seren_q;
  reg         fbben_q;
  // Assembled register words.
  wire [15:0] status_word;
  wire [15:0] cmd_word;
  wire [31:0] status_cmd;
  // Decoded accesses.
  wire        hit_id;
  wire        hit_sc;
  wire        wr_sc;
  // Per-flag set terms, sampled at a link clock edge.
  wire        set_par_err;
  wire        set_mabort;
  wire        set_tabort_rcvd;
  wire        set_tabort_sig;
  wire        set_mdpe;
  wire        serr_cause;

  assign hit_id = (reg_addr == `OFS_IDENT);
  assign hit_sc = (reg_addr == `OFS_STATUS_CMD);
  assign wr_sc  = reg_wr & hit_sc & ~satellite_mode;

  assign set_par_err = pci_edge & (ev_f[`EV_RD_INIT_PERR] | ev_f[`EV_WR_TGT_PERR] |
                                   ev_f[`EV_ADDR_PERR]);
  assign set_mabort = pci_edge & ev_f[`EV_MST_ABORT] & ~ev_f[`EV_MST_ABORT_SPC];
  assign set_tabort_rcvd = pci_edge & ev_f[`EV_TGT_ABORT_RCVD];
  assign set_tabort_sig = pci_edge & ev_f[`EV_TGT_ABORT_SIG];
  // Master data parity only counts while parity response is on.
  assign set_mdpe = pci_edge & ev_f[`EV_MST_PERR] & par_resp_en_q;
  assign serr_cause = (ev_f[`EV_ADDR_PERR] | ev_f[`EV_SPC_PERR]) & seren_q & par_resp_en_q;

  assign status_word = {par_err_q, sys_err_q, mabort_rcvd_q, tabort_rcvd_q, tabort_sig_q,
                        `DSEL_MEDIUM, mdpe_q, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0};
  assign cmd_word = {6'h00, fbben_q, seren_q, 1'b0, par_resp_en_q, 6'h00};
  assign status_cmd = {status_word, cmd_word};
  assign satellite_status_mirror = status_word;
  assign parity_response_enable = par_resp_en_q;

  // SERR drives low for each link cycle whose starting edge sees the cause; hardware has no other reason to
  // release it, so the pin follows a whole link period.
  always @(posedge clk_sys) begin
    if (srst) begin
      serr_oe <= 1'b0;
    end else if (pci_edge) begin
      serr_oe <= serr_cause;
    end
  end
  assign serr_out = 1'b0;

  // Identification contents; the loader overrides the reset defaults.
  always @(posedge clk_sys) begin
    if (srst) begin
      ident_q <= {DEVICE_ID_RESET, VENDOR_ID_RESET};
    end else if (id_load) begin
      ident_q[`ID_DEVICE_MSB:`ID_DEVICE_LSB] <= id_load_data[`ID_DEVICE_MSB:`ID_DEVICE_LSB];
      ident_q[`ID_VENDOR_MSB:`ID_VENDOR_LSB] <= id_load_data[`ID_VENDOR_MSB:`ID_VENDOR_LSB];
    end
  end

  // Flags and command bits; a set in the cycle of a clear wins.
  always @(posedge clk_sys) begin
    if (srst) begin
      par_err_q     <= 1'b0;
      sys_err_q     <= 1'b0;
      mabort_rcvd_q <= 1'b0;
      tabort_rcvd_q <= 1'b0;
      tabort_sig_q  <= 1'b0;
      mdpe_q        <= 1'b0;
      par_resp_en_q <= 1'b0;
      seren_q       <= 1'b0;
      fbben_q       <= 1'b0;
    end else begin
      par_err_q     <= (par_err_q & ~(wr_sc & reg_wdata[`ST_PAR_ERR])) | set_par_err;
      sys_err_q     <= (sys_err_q & ~(wr_sc & reg_wdata[`ST_SYS_ERR])) | (pci_edge & serr_cause);
      mabort_rcvd_q <= (mabort_rcvd_q & ~(wr_sc & reg_wdata[`ST_MABORT_RCVD])) | set_mabort;
      tabort_rcvd_q <= (tabort_rcvd_q & ~(wr_sc & reg_wdata[`ST_TABORT_RCVD])) | set_tabort_rcvd;
      tabort_sig_q  <= (tabort_sig_q & ~(wr_sc & reg_wdata[`ST_TABORT_SIG])) | set_tabort_sig;
      mdpe_q        <= (mdpe_q & ~(wr_sc & reg_wdata[`ST_MDPE])) | set_mdpe;
      if (wr_sc) begin
        par_resp_en_q <= reg_wdata[`CMD_PAR_RESP];
        seren_q <= reg_wdata[`CMD_SEREN];
        fbben_q <= reg_wdata[`CMD_FBBEN];
      end
    end
  end

  // Read port: data one cycle after the strobe; blocked or unmapped reads
  // return zero, and a blocked access of either kind raises reg_blocked.
  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata   <= 32'h00000000;
      reg_rvalid  <= 1'b0;
      reg_blocked <= 1'b0;
    end else begin
      reg_rvalid  <= reg_rd;
      reg_blocked <= (reg_rd | reg_wr) & satellite_mode & (hit_id | hit_sc);
      if (reg_rd) begin
        if (satellite_mode) begin
          reg_rdata <= 32'h00000000;
        end else if (hit_id) begin
          reg_rdata <= ident_q;
        end else if (hit_sc) begin
          reg_rdata <= status_cmd;
        end else begin
          reg_rdata <= 32'h00000000;
        end
      end
    end
  end

  // Link edges counted since the address phase started.
  reg [1:0] dsel_cnt_q;
  // Address phase level seen at the previous link edge.
  reg       aphase_prev_q;

  // devsel by medium
  // Devsel is driven on the second link edge after the address phase,
  // which is medium timing; it drops when a new address phase starts or at a later
  // edge where the flag is low and was low at the edge before, since transaction end lies outside this bank.
  always @(posedge clk_sys) begin
    if (srst) begin
      dsel_cnt_q    <= 2'h0;
      aphase_prev_q <= 1'b0;
      devsel_oe     <= 1'b0;
    end else if (pci_edge) begin
      aphase_prev_q <= ev_f[`EV_ADDR_PHASE];
      if (ev_f[`EV_ADDR_PHASE] & ~aphase_prev_q) begin
        dsel_cnt_q <= 2'h1;
        devsel_oe  <= 1'b0;
      end else if (dsel_cnt_q != 2'h0) begin
        if (dsel_cnt_q + 2'h1 == `DEVSEL_MEDIUM_EDGES + 2'h1) begin
          devsel_oe  <= 1'b1;
          dsel_cnt_q <= 2'h0;
        end else begin
          dsel_cnt_q <= dsel_cnt_q + 2'h1;
        end
      end else if (~ev_f[`EV_ADDR_PHASE] & ~aphase_prev_q) begin
        devsel_oe <= 1'b0;
      end
    end
  end
  assign devsel_out = 1'b0;

endmodule

// >>> test/pci_link_model.sv
`timescale 1ns/10ps
// Stand-in for the bus agents across the link: a free bus clock and event levels.
module pci_link_model (
  output logic       pci_clk,
  output logic [9:0] ev
);
  // A backplane clock runs free, so it is not stopped between events.
  initial pci_clk = 1'b0;
  always #24 pci_clk = ~pci_clk;
  initial ev = 10'h000;
  // Levels move after a falling edge so they are steady at the next rising edge.
  task automatic pulse(input logic [9:0] m);
    @(negedge pci_clk);
    ev = m;
    @(negedge pci_clk);
    ev = 10'h000;
  endtask
endmodule

// >>> test/pci_cfg_id_status_regs_sva.sv
`timescale 1ns/10ps
module pci_cfg_id_status_regs_sva (
  input wire        clk_sys,
  input wire        srst,
  input wire        satellite_mode,
  input wire [15:0] reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        reg_blocked,
  input wire        addr_phase,
  input wire        serr_oe,
  input wire        devsel_oe,
  input wire        parity_response_enable,
  input wire [15:0] satellite_status_mirror
);
  // Every check lives in the system clock domain and sleeps through reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  wire [15:0] st = satellite_status_mirror;  // Status word seen from outside.
  wire        hit = reg_addr == 16'hD000 || reg_addr == 16'hD004;  // Guarded offsets.
  // A flag may only drop when a one is written over it.
  property sticky(int b);
    st[b] && !(reg_wr && reg_wdata[b + 16]) |=> st[b];
  endproperty
  a_blocked_pulse: assert property (
    (reg_rd || reg_wr) && satellite_mode && hit |=> reg_blocked)
    else $error("blocked access gave no pulse");
  a_sat_read_zero: assert property (reg_rd && satellite_mode && hit |=> reg_rdata == 32'h0)
    else $error("blocked read leaked data");
  a_dsel_code_fixed: assert property (st[10:9] == 2'h1)
    else $error("devsel timing code wrong");
  a_fixed_ones: assert property (st[7] && st[5] && st[4])
    else $error("fixed status ones missing");
  a_par_flag_sticky: assert property (sticky(15))
    else $error("parity flag dropped");
  a_syserr_sticky: assert property (sticky(14))
    else $error("system error flag dropped");
  a_mabort_sticky: assert property (sticky(13))
    else $error("master abort flag dropped");
  a_serr_flag: assert property ($rose(serr_oe) |-> ##[0:2] st[14])
    else $error("system error flag not set");
  a_serr_enable: assert property ($rose(serr_oe) |-> parity_response_enable)
    else $error("system error without response enable");
  a_devsel_time: assert property ($rose(addr_phase) |-> ##[1:40] devsel_oe)
    else $error("devsel late");
  a_resp_en_write: assert property ($changed(parity_response_enable) |->
    $past(reg_wr && !satellite_mode && reg_addr == 16'hD004) &&
    parity_response_enable == $past(reg_wdata[6]))
    else $error("response enable changed without write");
  c_serr: cover property ($rose(serr_oe));
  c_devsel: cover property ($rose(devsel_oe));
  c_blocked: cover property (reg_blocked);
endmodule
bind pci_cfg_id_status_regs pci_cfg_id_status_regs_sva chk_u (.clk_sys(clk_sys), .srst(srst),
  .satellite_mode(satellite_mode), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_blocked(reg_blocked),
  .addr_phase(addr_phase), .serr_oe(serr_oe), .devsel_oe(devsel_oe),
  .parity_response_enable(parity_response_enable),
  .satellite_status_mirror(satellite_status_mirror));

// >>> test/pci_cfg_id_status_regs_tb_top.sv
`timescale 1ns/10ps
module pci_cfg_id_status_regs_tb_top;
  logic        clk_sys = 1'b0;  // System clock.
  logic        srst = 1'b1;     // Reset, held at start.
  logic        satellite_mode = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic        id_load = 1'b0;
  logic [31:0] id_load_data = 32'h0;
  logic [31:0] rdv;             // Last read data.
  logic        blk;             // Last blocked pulse.
  wire  [31:0] reg_rdata;
  wire  [15:0] mirror;
  wire  [9:0]  ev;
  wire         pci_clk, reg_rvalid, reg_blocked, serr_out, serr_oe;
  wire         devsel_out, devsel_oe, par_resp_en;
  int          fails = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  pci_link_model link_u (.pci_clk(pci_clk), .ev(ev));
  // Identity values are arbitrary.
  pci_cfg_id_status_regs #(.DEVICE_ID_RESET(16'hA1B2), .VENDOR_ID_RESET(16'hC3D4)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .satellite_mode(satellite_mode), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_blocked(reg_blocked), .id_load(id_load),
    .id_load_data(id_load_data), .pci_clk(pci_clk), .rd_init_perr(ev[0]),
    .wr_tgt_perr(ev[1]), .addr_perr(ev[2]), .spc_perr(ev[3]), .mst_abort(ev[4]),
    .mst_abort_special(ev[5]), .tgt_abort_rcvd(ev[6]), .tgt_abort_sig(ev[7]),
    .mst_perr(ev[8]), .addr_phase(ev[9]), .serr_out(serr_out), .serr_oe(serr_oe),
    .devsel_out(devsel_out), .devsel_oe(devsel_oe), .parity_response_enable(par_resp_en),
    .satellite_status_mirror(mirror));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One strobe, write or read as w selects, is held from one falling edge through the next rising edge.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rdv = reg_rdata;
    blk = reg_blocked;
  endtask
  task automatic t_reset_vals();
    acc(0, 16'hD000, 0); chk(rdv, 32'hA1B2_C3D4);
    acc(0, 16'hD004, 0); chk(rdv, 32'h02B0_0000);
    acc(0, 16'hD008, 0); chk(rdv, 32'h0);
  endtask
  task automatic t_ident();
    @(negedge clk_sys);
    id_load = 1'b1;
    id_load_data = 32'h9A6B_4C3D;
    @(negedge clk_sys);
    id_load = 1'b0;
    acc(1, 16'hD000, 32'hFFFF_FFFF);
    acc(0, 16'hD000, 0); chk(rdv, 32'h9A6B_4C3D);
  endtask
  task automatic t_command();
    acc(1, 16'hD004, 32'hFFFF_FFFF);
    acc(0, 16'hD004, 0); chk(rdv, 32'h02B0_0340);
    chk({31'h0, par_resp_en}, 32'h1);
  endtask
  // Each event row but the special master abort one raises its flag (address parity also system error), keeps it over a zero write, then clears it.
  task automatic t_events();
    logic [9:0] m [9] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h030, 10'h040,
                          10'h080, 10'h100};
    int b [9] = '{31, 31, 31, 30, 29, 29, 28, 27, 24};
    logic [31:0] c;
    for (int i = 0; i < 9; i++) begin
      c = (i == 0) ? 32'h0 : 32'h0000_0340;
      acc(1, 16'hD004, c);
      link_u.pulse(m[i]);
      for (int k = 0; k < 40 && !mirror[b[i] - 16]; k++) @(negedge clk_sys);
      acc(0, 16'hD004, 0); chk(rdv[b[i]], i != 5);
      acc(1, 16'hD004, c);
      acc(0, 16'hD004, 0); chk(rdv[b[i]], i != 5);
      acc(1, 16'hD004, 32'hF900_0340);
      acc(0, 16'hD004, 0); chk({rdv[31:27], rdv[24]}, 0);
    end
  endtask
  task automatic t_devsel();
    link_u.pulse(10'h200);
    for (int k = 0; k < 60 && !devsel_oe; k++) @(negedge clk_sys);
    chk({devsel_out, devsel_oe}, 32'h1);
  endtask
  task automatic t_satellite();
    @(negedge clk_sys);
    satellite_mode = 1'b1;
    acc(0, 16'hD000, 0); chk(blk, 1);
    chk(rdv, 32'h0);
    acc(1, 16'hD004, 0); chk(blk, 1);
    chk(mirror[10:9], 2'h1);
    satellite_mode = 1'b0;
    acc(0, 16'hD004, 0); chk(rdv[15:0], 16'h0340);
  endtask
  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A run that outlives its expected length is cut short and fails.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    t_reset_vals();
    t_ident();
    t_command();
    t_events();
    t_devsel();
    t_satellite();
    stop_test();
  end
endmodule
